// *** ldcc_cmd_decoder.v ***
// Command decoder and configuration registers of the LCD driver
`timescale 1ns/100ps
`default_nettype none
`include "ldcc_defines.vh"
module ldcc_cmd_decoder (
	// Clock and reset
	input  wire        clock,
	input  wire        reset_n,
	// Host parallel bus pins
	input  wire        cmd_data_sel,
	input  wire        read_strobe_n,
	input  wire        write_strobe_n,
	input  wire [7:0]  host_data,
	// Display memory access completions
	input  wire        memory_access_done,
	// Configuration state
	output reg  [4:0]  display_first_row,
	output reg  [1:0]  memory_page_select,
	output reg  [6:0]  column_pointer,
	output reg         segment_order_select,
	output reg         low_power_hold_enable,
	output reg         scan_ratio_select,
	output reg         display_enable,
	// Timing control
	output wire        internal_clock_enable,
	output wire        outputs_at_supply,
	// Row and column mapping
	output wire [79:0] row_pointer_bits,
	output wire [15:0] common_active,
	output wire [6:0]  segment0_column,
	output wire [4:0]  page_first_row
);
	// Pin synchronisers
	reg  [1:0] cd_sync;
	reg  [1:0] rd_sync;
	reg  [1:0] wr_sync;
	reg  [7:0] data_s1;
	reg  [7:0] data_s2;
	reg        wr_seen;
	wire       write_cmd;
	wire [7:0] code;
	wire       write_edge;

	always @(posedge clock) begin
		if (!reset_n) begin
			cd_sync <= 2'b11;
			rd_sync <= 2'b11;
			wr_sync <= 2'b11;
			data_s1 <= 8'h00;
			data_s2 <= 8'h00;
			wr_seen <= 1'b0;
		end else begin
			cd_sync <= {cd_sync[0], cmd_data_sel};
			rd_sync <= {rd_sync[0], read_strobe_n};
			wr_sync <= {wr_sync[0], write_strobe_n};
			data_s1 <= host_data;
			data_s2 <= data_s1;
			wr_seen <= write_cmd;
		end
	end

	assign code = data_s2;
	assign write_cmd = !cd_sync[1] && rd_sync[1] && !wr_sync[1];
	// One decode per strobe, taken on its leading edge
	assign write_edge = write_cmd && !wr_seen;

	// Stopped logic still accepts commands so static mode can be left
	assign internal_clock_enable = !low_power_hold_enable;
	assign outputs_at_supply = low_power_hold_enable && !display_enable;

	// Master part; a segment-only build clears this and follows the master's timing
	localparam HAS_DUTY_REG = 1'b1;

	always @(posedge clock) begin
		if (!reset_n) begin
			display_first_row     <= `LDCC_RST_START;
			memory_page_select    <= `LDCC_RST_PAGE;
			column_pointer        <= `LDCC_RST_COLUMN;
			segment_order_select  <= `LDCC_RST_MAP;
			low_power_hold_enable <= `LDCC_RST_STATIC;
			scan_ratio_select     <= `LDCC_RST_DUTY;
			display_enable        <= `LDCC_RST_DISP;
		end else if (write_edge) begin
			if (!code[7]) begin
				// Out of range values are kept as written
				column_pointer <= code[6:0];
			end else if (code[7:5] == `LDCC_CODE_START_HI) begin
				display_first_row <= code[4:0];
			end else if (code[7:2] == `LDCC_CODE_PAGE_HI) begin
				memory_page_select <= code[1:0];
			end else if (code[7:1] == `LDCC_CODE_MAP) begin
				segment_order_select <= code[0];
			end else if (code[7:1] == `LDCC_CODE_STATIC) begin
				low_power_hold_enable <= code[0];
			end else if ((code[7:1] == `LDCC_CODE_DUTY) && HAS_DUTY_REG) begin
				scan_ratio_select <= code[0];
			end else if (code[7:1] == `LDCC_CODE_DISP) begin
				display_enable <= code[0];
			end else begin
				// Unknown codes leave every register as it was
				display_first_row <= display_first_row;
			end
		end else if (memory_access_done && internal_clock_enable) begin
			if (column_pointer >= `LDCC_COL_LAST) begin
				column_pointer <= 7'h00;
			end else begin
				column_pointer <= column_pointer + 7'h01;
			end
		end
	end

	// First segment column, reversed or normal
	assign segment0_column = segment_order_select ? `LDCC_COLUMNS : 7'h00;
	// Page n starts at row 8n
	assign page_first_row = {memory_page_select, 3'b000};

	// Only sixteen commons exist on this device
	genvar gi;
	generate
		for (gi = 0; gi < `LDCC_COMMONS; gi = gi + 1) begin : g_com
			localparam [4:0] COM_IDX = gi;
			ldcc_row_map u_map (
				.display_first_row (display_first_row),
				.scan_ratio_select (scan_ratio_select),
				.common_index      (COM_IDX),
				.memory_row        (row_pointer_bits[gi*5 +: 5]),
				.row_scanned       (common_active[gi])
			);
		end
	endgenerate
endmodule
`default_nettype wire

// *** ldcc_defines.vh ***
// Constants for the display configuration command decoder
// Notes on behaviour
// - Start row maps first common, wraps after 31
// - Scan 32 rows long duty, 16 short
// - Only commons 0 to 15 driven here
// - Codes C0..DF load start row
// - Commands only when select low, write strobe
// - Four pages of 80 bytes, eight rows
// - Page n covers rows 8n..8n+7
// - Codes B8..BB load memory page
// - Column advances after each memory access; here not when static or when a command write edge lands in the same cycle
// - Column wraps from 79 to zero
// - Codes 00..4F load column pointer; here any code 00..7F loads it
// - Mapping set reverses column to segment order
// - A0 normal order, A1 reversed order
// - Static drive stops internal clocking
// - Display off plus static: outputs high, held
// - A4 static off, A5 static on
// - Duty bit set means 1/32, clear 1/16
// - A8 short duty, A9 long duty
// - Segment-only variant takes duty from master
// - Reset: page three, column and start zero
// - AF display on, AE display off
`ifndef LDCC_DEFINES_VH
`define LDCC_DEFINES_VH
`define LDCC_COLUMNS        7'h4f
`define LDCC_COL_LAST       7'h4f
`define LDCC_ROWS_LONG      5'h1f
`define LDCC_ROWS_SHORT     5'h0f
`define LDCC_COMMONS        16
`define LDCC_CODE_START_HI  3'b110
`define LDCC_CODE_PAGE_HI   6'b10_1110
`define LDCC_CODE_MAP       7'b101_0000
`define LDCC_CODE_STATIC    7'b101_0010
`define LDCC_CODE_DUTY      7'b101_0100
`define LDCC_CODE_DISP      7'b101_0111
`define LDCC_RST_START      5'h00
`define LDCC_RST_PAGE       2'b11
`define LDCC_RST_COLUMN     7'h00
`define LDCC_RST_MAP        1'b0
`define LDCC_RST_STATIC     1'b0
`define LDCC_RST_DUTY       1'b1
`define LDCC_RST_DISP       1'b0
`endif

// *** ldcc_row_map.v ***
// Common position to memory row mapping, one instance per common
`timescale 1ns/100ps
`default_nettype none
`include "ldcc_defines.vh"
module ldcc_row_map (
	// Configuration
	input  wire [4:0] display_first_row,
	input  wire       scan_ratio_select,
	// Common position in, memory row out
	input  wire [4:0] common_index,
	output wire [4:0] memory_row,
	output wire       row_scanned
);
	// Five bit sum wraps from row 31 to row 0 by itself
	assign memory_row = display_first_row + common_index;
	assign row_scanned = scan_ratio_select ? (common_index <= `LDCC_ROWS_LONG) :
		(common_index <= `LDCC_ROWS_SHORT);
endmodule
`default_nettype wire

// *** ldcc_checker.sv ***
// Port assertions for the configuration decoder
`timescale 1ns/100ps
`default_nettype none
module ldcc_checker (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	// Host bus pins
	input wire logic        cmd_data_sel,
	input wire logic        read_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic [7:0]  host_data,
	// Memory access completions
	input wire logic        memory_access_done,
	// Decoder state and mapping
	input wire logic        segment_order_select,
	input wire logic        low_power_hold_enable,
	input wire logic        display_enable,
	input wire logic        internal_clock_enable,
	input wire logic        outputs_at_supply,
	input wire logic [4:0]  display_first_row,
	input wire logic [4:0]  page_first_row,
	input wire logic [1:0]  memory_page_select,
	input wire logic [6:0]  column_pointer,
	input wire logic [6:0]  segment0_column,
	input wire logic [79:0] row_pointer_bits
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Strobe idle three cycles, so no command competes with the step
	sequence step_s;
		write_strobe_n[*3] ##0 memory_access_done && !low_power_hold_enable;
	endsequence
	a_clk_gate: assert property (internal_clock_enable == !low_power_hold_enable)
		else $error("clock gate wrong");
	a_supply_mode: assert property (outputs_at_supply == (low_power_hold_enable && !display_enable))
		else $error("supply mode wrong");
	a_seg_map: assert property (segment0_column == (segment_order_select ? 7'h4f : 7'h00))
		else $error("segment map wrong");
	a_page_row: assert property (page_first_row == {memory_page_select, 3'h0})
		else $error("page row wrong");
	a_last_row: assert property (row_pointer_bits[79:75] == display_first_row + 5'h0f)
		else $error("row wrap wrong");
	a_col_step: assert property (step_s ##0 column_pointer < 7'h4f
		|=> column_pointer == $past(column_pointer) + 7'h01) else $error("column step wrong");
	a_col_wrap: assert property (step_s ##0 column_pointer == 7'h4f
		|=> column_pointer == 7'h00) else $error("column wrap wrong");
	a_static_hold: assert property (write_strobe_n[*3] ##0 low_power_hold_enable
		|=> $stable(column_pointer)) else $error("column moved in static mode");
	a_start_load: assert property ($fell(write_strobe_n) && !cmd_data_sel && read_strobe_n
		&& host_data[7:5] == 3'h6 |-> ##3 display_first_row == $past(host_data[4:0], 3))
		else $error("start row load wrong");
	cover property (step_s ##0 column_pointer == 7'h4f);
	cover property (outputs_at_supply);
	cover property (segment_order_select);
endmodule
bind ldcc_cmd_decoder ldcc_checker chk_i (.*);
`default_nettype wire

// *** ldcc_host.sv ***
// Host bus model issuing command and data bytes
`timescale 1ns/100ps
`default_nettype none
module ldcc_host (
	// Clock
	input  wire logic       clock,
	// Bus pins
	output var  logic       cmd_data_sel,
	output var  logic       read_strobe_n,
	output var  logic       write_strobe_n,
	output var  logic [7:0] host_data,
	// Bias circuit power-save control
	output var  logic       power_save
);
	initial {cmd_data_sel, read_strobe_n, write_strobe_n, host_data} = 11'h700;
	initial power_save = 1'b0;
	task send(input logic cd, input logic [7:0] d);
		@(negedge clock);
		{cmd_data_sel, host_data, write_strobe_n} = {cd, d, 1'b0};
		// Bias current cut follows the static drive command
		if (!cd && d[7:1] == 7'h52)
			power_save = d[0];
		repeat (3) @(negedge clock);
		// Released bus shows the inverse, not a stale byte
		{host_data, write_strobe_n} = {~d, 1'b1};
		repeat (3) @(negedge clock);
		cmd_data_sel = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** lcd_display_config_commands_test.sv ***
// Self-checking bench for the configuration decoder
`timescale 1ns/100ps
`default_nettype none
module lcd_display_config_commands_test;
	logic        clock = 0, reset_n = 0, memory_access_done = 0;
	logic        cmd_data_sel, read_strobe_n, write_strobe_n, segment_order_select;
	logic        low_power_hold_enable, scan_ratio_select, display_enable;
	logic        internal_clock_enable, outputs_at_supply, power_save;
	logic [7:0]  host_data;
	logic [4:0]  display_first_row, page_first_row;
	logic [1:0]  memory_page_select;
	logic [6:0]  column_pointer, segment0_column;
	logic [79:0] row_pointer_bits;
	logic [15:0] common_active;
	logic [17:0] keep;
	int          compares = 0, miscompares = 0, cycles = 0;
	wire  [17:0] cfg = {display_first_row, memory_page_select, column_pointer,
		segment_order_select, low_power_hold_enable, scan_ratio_select, display_enable};
	ldcc_host host (.*);
	ldcc_cmd_decoder uut (.*);
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	task chk(input logic [17:0] got, input logic [17:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task pulse;
		@(negedge clock) memory_access_done = 1;
		@(negedge clock) memory_access_done = 0;
	endtask
	task t_start_duty;
		host.send(0, 8'hdf);
		chk(row_pointer_bits[79:75], 18'h0_000e);
		host.send(0, 8'hc2);
		chk(row_pointer_bits[4:0], 18'h0_0002);
		host.send(0, 8'ha8);
		chk({common_active, scan_ratio_select}, 18'h1_fffe);
		host.send(0, 8'ha9);
		chk(scan_ratio_select, 18'h0_0001);
	endtask
	task t_pages_map;
		for (int i = 0; i < 4; i++) begin
			host.send(0, 8'hb8 + 8'(i));
			chk(page_first_row, 18'(i * 8));
		end
		host.send(0, 8'ha1);
		chk(segment0_column, 18'h0_004f);
		host.send(0, 8'ha0);
		chk(segment0_column, 18'h0_0000);
	endtask
	task t_column_static;
		host.send(0, 8'hb8);
		host.send(0, 8'h4e);
		pulse;
		chk(column_pointer, 18'h0_004f);
		pulse;
		chk(column_pointer, 18'h0_0000);
		host.send(0, 8'ha5);
		host.send(0, 8'hae);
		pulse;
		chk({internal_clock_enable, outputs_at_supply, column_pointer}, 18'h0_0080);
		chk(power_save, 18'h0_0001);
		host.send(0, 8'ha4);
		host.send(0, 8'haf);
		chk({internal_clock_enable, outputs_at_supply, display_enable}, 18'h0_0005);
		keep = cfg;
		host.send(1, 8'hc5);
		host.send(0, 8'hff);
		chk(cfg, keep);
	endtask
	task tally_and_finish;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clock);
		reset_n = 1;
		chk(cfg, 18'h0_1802);
		t_start_duty;
		t_pages_map;
		t_column_static;
		tally_and_finish;
	end
endmodule
`default_nettype wire
